/* pkg/vlc_cfg.svh */
// constants of the voltage loop compensator: offsets, fields, resets, timing
`ifndef VLC_CFG_SVH
`define VLC_CFG_SVH
// register byte offsets
`define VLC_A_CTRL 8'h00
`define VLC_A_OPER 8'h04
`define VLC_A_VNOM 8'h08
`define VLC_A_VHI 8'h0c
`define VLC_A_VLO 8'h10
`define VLC_A_TIME 8'h14
`define VLC_A_STAT 8'h18
`define VLC_A_MON 8'h1c
`define VLC_A_BANK 8'h40
`define VLC_A_BEND 8'ha0
`define VLC_BANK_WORDS 3'h5
// field positions
`define VLC_OP_SUPP 2
`define VLC_T_SINST 16
`define VLC_M_ERR 16
// reset values
`define VLC_RST_JTAG 1'b1
`define VLC_RST_PERIOD 12'h190
`define VLC_RST_SINST 12'h12c
// timing
`define VLC_CLK_MHZ 200
`define VLC_STARTUP_US 10
`define VLC_STARTUP_CYC ((`VLC_STARTUP_US) * (`VLC_CLK_MHZ))
`define VLC_SLEW_UV_PER_MS 156000
`define VLC_REF_LSB_UV 1563
`define VLC_SLEW_CYC (((`VLC_REF_LSB_UV) * (`VLC_CLK_MHZ) * 1000) / (`VLC_SLEW_UV_PER_MS))
// datapath limits
`define VLC_ERR_POS 6'sh1f
`define VLC_ERR_NEG 6'sh20
`define VLC_DUTY_MAX 12'hfff
`endif

/* pkg/vlc_pkg.sv */
// types of the voltage loop compensator
package vlc_pkg;
  typedef enum logic [1:0] {MD_RESET, MD_START, MD_RUN} vlc_mode_e;
  typedef struct packed {
    logic       supp;
    logic [1:0] sel;
  } vlc_op_t;
  typedef struct packed {
    logic [9:0] vnom;
    logic [9:0] vhi;
    logic [9:0] vlo;
    vlc_op_t    op;
  } vlc_nvm_t;
  typedef struct packed {
    logic [2:0][9:0] cz;
    logic [1:0][9:0] ap;
    logic [2:0][9:0] bz;
    logic [4:0][5:0] rg;
    logic [3:0][5:0] lim;
    logic [1:0]      gcode;
  } vlc_bank_t;
  typedef struct packed {
    logic       hit;
    logic [1:0] idx;
    logic [2:0] wd;
  } vlc_bdec_t;
  typedef struct packed {
    vlc_mode_e          mode;
    logic [11:0]        tmr;
    logic [11:0]        slew;
    logic [11:0]        pcnt;
    logic               jtag;
    vlc_op_t            op;
    logic [9:0]         vnom;
    logic [9:0]         vhi;
    logic [9:0]         vlo;
    logic [11:0]        period;
    logic [11:0]        sinst;
    vlc_bank_t [2:0]    bank;
    logic [1:0]         bsel;
    logic               sat;
    logic signed [5:0]  err;
    logic [9:0]         vref;
    logic signed [17:0] x1;
    logic signed [17:0] x2;
    logic signed [17:0] y1;
    logic signed [17:0] y2;
    logic signed [17:0] z1;
    logic [11:0]        duty;
    logic               dv;
    logic               smp;
    logic               ack;
    logic [31:0]        dat;
    logic               run;
    logic [1:0]         gcode;
    logic               fmask;
  } vlc_state_t;
endpackage

/* design/vlc_top.sv */
// voltage loop compensator: supervision, reference slew and 3-pole/3-zero loop
// Functional notes
// - boundary-scan port is enabled straight out of reset
// - supply above threshold starts the internal startup sequence
// - after startup delay, run with configuration from nonvolatile memory
// - device stays in reset while external reset input is low
// - target is nominal, high margin or low margin per operation setting
// - operation option suppresses voltage faults while margined
// - feedback sampled at programmed instant within switching period
// - error is 10-bit setpoint minus feedback, gained, then converted
// - gain code n gives gain 2^n, step 8>>n mV
// - front end gain is stored in every coefficient bank
// - converter clamps out-of-range error to -32 or 31
// - while saturated, move reference to bring error back in range
// - recovery slew is 0.156 V/ms at the feedback inputs
// - error passes nonlinear gain then second-order IIR
// - first-order IIR follows, adding third zero and pole
// - bank 0 ramps, bank 1 regulation, bank 2 light load
// - four signed, possibly asymmetric, nonlinear thresholds
// - errors below lowest threshold use region gain 0
// - output duty code spans 0 to 100 percent
`timescale 1ns/1ps
`default_nettype none
`include "vlc_cfg.svh"
module vlc_top import vlc_pkg::*; (
  // clock and reset
  input  wire logic        core_clk_i,
  input  wire logic        arst_n_i,
  // wishbone slave
  input  wire logic        wb_cyc_i,
  input  wire logic        wb_stb_i,
  input  wire logic        wb_we_i,
  input  wire logic [31:0] wb_adr_i,
  input  wire logic [3:0]  wb_sel_i,
  input  wire logic [31:0] wb_dat_i,
  output logic             wb_ack_o,
  output logic [31:0]      wb_dat_o,
  // supervision
  input  wire logic        supply_ok_i,
  input  wire logic        external_reset_n_i,
  input  wire vlc_nvm_t    nvm_cfg_i,
  // loop inputs
  input  wire logic        ramp_active_i,
  input  wire logic        light_load_i,
  input  wire logic        err_valid_i,
  input  wire logic [5:0]  err_code_i,
  // loop outputs
  output logic             jtag_en_o,
  output logic             run_o,
  output logic [9:0]       vref_o,
  output logic [1:0]       front_end_gain_code_o,
  output logic             sample_o,
  output logic [11:0]      duty_o,
  output logic             duty_valid_o,
  output logic             fault_mask_o
);

  // both counts fit twelve bits at the fixed core clock
  localparam logic [11:0] StartCyc = 12'(`VLC_STARTUP_CYC);
  localparam logic [11:0] SlewCyc = 12'(`VLC_SLEW_CYC);

  vlc_state_t s_q;
  vlc_state_t s_d;

  // bank region decode
  // words five to seven of a bank fall through as unmapped
  function automatic vlc_bdec_t bank_dec(input logic [7:0] a);
    vlc_bdec_t r;
    r.idx = 2'(a[7:5] - 3'h2);
    r.wd  = a[4:2];
    r.hit = (a >= `VLC_A_BANK) && (a < `VLC_A_BEND) && (r.wd < `VLC_BANK_WORDS);
    return r;
  endfunction

  // operating state to coefficient bank
  // ramps take priority over light load
  function automatic logic [1:0] bank_sel(input logic ramp, input logic light);
    if (ramp) begin
      return 2'h0;
    end
    return light ? 2'h2 : 2'h1;
  endfunction

  // region gain for an error, thresholds scanned highest first so the lowest match wins
  // four signed limits
  function automatic logic [5:0] nl_gain(input vlc_bank_t b, input logic signed [5:0] e);
    logic [5:0] g;
    g = b.rg[4];
    // scanning down leaves the lowest matching limit in g
    for (int i = 3; i >= 0; i--) begin
      if (e < $signed(b.lim[i])) begin
        g = b.rg[i];
      end
    end
    return g;
  endfunction

  // saturate an accumulator to the 18-bit state width
  // clipping instead of wrapping keeps a large step from flipping sign
  function automatic logic signed [17:0] sat18(input logic signed [31:0] v);
    if (v > 32'sh1ffff) begin
      return 18'sh1ffff;
    end
    if (v < -32'sh20000) begin
      return -18'sh20000;
    end
    return v[17:0];
  endfunction

  // error code in millivolts for the gain code in use
  function automatic logic [9:0] err_mv(input logic signed [5:0] e, input logic [1:0] gc);
    return 10'(10'(e) <<< (2'h3 - gc));
  endfunction

  // datapath terms
  vlc_bank_t          bk;
  vlc_bdec_t          bd;
  logic signed [5:0]  e_w;
  logic [5:0]         g_w;
  logic signed [17:0] x_w;
  logic signed [31:0] acc_a;
  logic signed [17:0] y_w;
  logic signed [31:0] acc_b;
  logic signed [17:0] z_w;
  logic [11:0]        duty_w;
  logic [9:0]         tgt_w;

  assign bk = s_q.bank[s_q.bsel];
  assign bd = bank_dec(wb_adr_i[7:0]);
  assign e_w = $signed(err_code_i);
  assign g_w = nl_gain(bk, e_w);
  // region gain is Q2.4, the shift restores the error scale
  // nonlinear gain stage
  assign x_w = (18'(e_w) * $signed({12'h000, g_w})) >>> 4;
  // Q2.8 products are summed at 32 bits before the shift
  // second-order section
  assign acc_a = $signed(bk.bz[0]) * x_w + $signed(bk.bz[1]) * s_q.x1
               + $signed(bk.bz[2]) * s_q.x2 - $signed(bk.ap[0]) * s_q.y1
               - $signed(bk.ap[1]) * s_q.y2;
  assign y_w = sat18(acc_a >>> 8);
  assign acc_b = $signed(bk.cz[0]) * y_w + $signed(bk.cz[1]) * s_q.y1
               - $signed(bk.cz[2]) * s_q.z1;
  assign z_w = sat18(acc_b >>> 8);
  // negative demand stops at zero duty instead of wrapping
  // clamp to the 0..100 percent code
  assign duty_w = (z_w < 0) ? 12'h000 :
                  (z_w > $signed({6'h00, `VLC_DUTY_MAX})) ? `VLC_DUTY_MAX : z_w[11:0];

  // outside saturation the reference walks to its target, it never jumps
  // target select; the host keeps these codes legal
  // nominal or margin target
  always_comb begin
    unique case (s_q.op.sel)
      2'h1: tgt_w = s_q.vhi;
      2'h2: tgt_w = s_q.vlo;
      default: tgt_w = s_q.vnom;
    endcase
  end

  // next-state logic
  always_comb begin
    s_d = s_q;
    s_d.ack = 1'b0;
    s_d.smp = 1'b0;
    s_d.dv = 1'b0;
    s_d.bsel = bank_sel(ramp_active_i, light_load_i);
    // wishbone access, one wait-free answer per request
    // a high ack blocks a second take while stb is still held
    if (wb_cyc_i && wb_stb_i && !s_q.ack) begin
      s_d.ack = 1'b1;
      s_d.dat = 32'h0000_0000;
      unique case (wb_adr_i[7:0])
        `VLC_A_CTRL: s_d.dat = {31'h0, s_q.jtag};
        `VLC_A_OPER: s_d.dat = {29'h0, s_q.op};
        `VLC_A_VNOM: s_d.dat = {22'h0, s_q.vnom};
        `VLC_A_VHI:  s_d.dat = {22'h0, s_q.vhi};
        `VLC_A_VLO:  s_d.dat = {22'h0, s_q.vlo};
        `VLC_A_TIME: s_d.dat = {4'h0, s_q.sinst, 4'h0, s_q.period};
        `VLC_A_STAT: s_d.dat = {27'h0, s_q.bsel, s_q.sat, s_q.mode};
        `VLC_A_MON:  s_d.dat = {6'h0, err_mv(s_q.err, bk.gcode), 6'h0, s_q.vref};
        default: begin
          if (bd.hit) begin
            unique case (bd.wd)
              3'h0: s_d.dat = {6'h0, s_q.bank[bd.idx].lim, s_q.bank[bd.idx].gcode};
              3'h1: s_d.dat = {2'h0, s_q.bank[bd.idx].rg};
              3'h2: s_d.dat = {2'h0, s_q.bank[bd.idx].bz};
              3'h3: s_d.dat = {12'h0, s_q.bank[bd.idx].ap};
              default: s_d.dat = {2'h0, s_q.bank[bd.idx].cz};
            endcase
          end
        end
      endcase
      if (wb_we_i) begin
        unique case (wb_adr_i[7:0])
          `VLC_A_CTRL: s_d.jtag = wb_dat_i[0];
          `VLC_A_OPER: s_d.op = wb_dat_i[2:0];
          `VLC_A_VNOM: s_d.vnom = wb_dat_i[9:0];
          `VLC_A_VHI:  s_d.vhi = wb_dat_i[9:0];
          `VLC_A_VLO:  s_d.vlo = wb_dat_i[9:0];
          `VLC_A_TIME: begin
            s_d.period = wb_dat_i[11:0];
            s_d.sinst = wb_dat_i[`VLC_T_SINST +: 12];
          end
          default: begin
            // gain code lives in each bank
            if (bd.hit) begin
              unique case (bd.wd)
                3'h0: {s_d.bank[bd.idx].lim, s_d.bank[bd.idx].gcode} = wb_dat_i[25:0];
                3'h1: s_d.bank[bd.idx].rg = wb_dat_i[29:0];
                3'h2: s_d.bank[bd.idx].bz = wb_dat_i[29:0];
                3'h3: s_d.bank[bd.idx].ap = wb_dat_i[19:0];
                default: s_d.bank[bd.idx].cz = wb_dat_i[29:0];
              endcase
            end
          end
        endcase
      end
    end
    // supervision and loop sequencing
    unique case (s_q.mode)
      MD_RESET: begin
        // both conditions must hold at one edge to start the delay
        // supply good starts startup
        if (supply_ok_i && external_reset_n_i) begin
          s_d.mode = MD_START;
          s_d.tmr = 12'h000;
        end
      end
      MD_START: begin
        if (s_q.tmr == StartCyc - 12'h001) begin
          // the stored image is taken once, at the end of the delay
          // load stored configuration
          s_d.mode = MD_RUN;
          s_d.vnom = nvm_cfg_i.vnom;
          s_d.vhi = nvm_cfg_i.vhi;
          s_d.vlo = nvm_cfg_i.vlo;
          s_d.op = nvm_cfg_i.op;
          s_d.vref = nvm_cfg_i.vnom;
          s_d.pcnt = 12'h000;
          s_d.slew = 12'h000;
        end else begin
          s_d.tmr = s_q.tmr + 12'h001;
        end
      end
      MD_RUN: begin
        // a sample instant beyond the period never fires
        // sample instant within the period
        s_d.pcnt = (s_q.pcnt >= s_q.period) ? 12'h000 : s_q.pcnt + 12'h001;
        s_d.smp = (s_q.pcnt == s_q.sinst);
        if (err_valid_i) begin
          s_d.err = e_w;
          // a clamped code is the only sign of an out-of-range error
          // clamped code marks saturation
          s_d.sat = (e_w == `VLC_ERR_POS) || (e_w == `VLC_ERR_NEG);
          s_d.x1 = x_w;
          s_d.x2 = s_q.x1;
          s_d.y1 = y_w;
          s_d.y2 = s_q.y1;
          s_d.z1 = z_w;
          s_d.duty = duty_w;
          s_d.dv = 1'b1;
        end
        // the interval is counted in core clocks, which fixes the rate
        // one reference step per slew interval
        if (s_q.slew == SlewCyc - 12'h001) begin
          s_d.slew = 12'h000;
          if (s_q.sat) begin
            if (s_q.err > 0 && s_q.vref != 10'h000) begin
              s_d.vref = s_q.vref - 10'h001;
            end else if (s_q.err < 0 && s_q.vref != 10'h3ff) begin
              s_d.vref = s_q.vref + 10'h001;
            end
          end else if (s_q.vref < tgt_w) begin
            s_d.vref = s_q.vref + 10'h001;
          end else if (s_q.vref > tgt_w) begin
            s_d.vref = s_q.vref - 10'h001;
          end
        end else begin
          s_d.slew = s_q.slew + 12'h001;
        end
      end
    endcase
    // bus registers survive so the host can prepare the next start
    // external reset holds the loop in reset
    if (!supply_ok_i || !external_reset_n_i) begin
      s_d.mode = MD_RESET;
      s_d.sat = 1'b0;
      s_d.err = 6'sh00;
      s_d.x1 = 18'sh0;
      s_d.x2 = 18'sh0;
      s_d.y1 = 18'sh0;
      s_d.y2 = 18'sh0;
      s_d.z1 = 18'sh0;
      s_d.duty = 12'h000;
      s_d.dv = 1'b0;
      s_d.smp = 1'b0;
    end
    // derived outputs registered from the next state, keeping their timing
    s_d.run = (s_d.mode == MD_RUN);
    // gain code of the bank in use
    s_d.gcode = s_d.bank[s_d.bsel].gcode;
    s_d.fmask = s_d.op.supp && ((s_d.op.sel == 2'h1) || (s_d.op.sel == 2'h2));
  end

  // state register
  // the asynchronous reset loads constants only, functional reset lives above
  always_ff @(posedge core_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      s_q <= '0;
      s_q.jtag <= `VLC_RST_JTAG;
      s_q.period <= `VLC_RST_PERIOD;
      s_q.sinst <= `VLC_RST_SINST;
      s_q.bsel <= 2'h1;
    end else begin
      s_q <= s_d;
    end
  end

  // outputs straight from state
  assign wb_ack_o = s_q.ack;
  assign wb_dat_o = s_q.dat;
  assign jtag_en_o = s_q.jtag;
  assign run_o = s_q.run;
  assign vref_o = s_q.vref;
  // gain code of the active bank
  assign front_end_gain_code_o = s_q.gcode;
  assign sample_o = s_q.smp;
  assign duty_o = s_q.duty;
  assign duty_valid_o = s_q.dv;
  // fault mask from its register
  assign fault_mask_o = s_q.fmask;

endmodule
`default_nettype wire

/* verif/vlc_top_asserts.sv */
// port assertions of the voltage loop compensator
`timescale 1ns/1ps
`default_nettype none
module vlc_top_asserts import vlc_pkg::*; (
  // clock and reset
  input wire logic        core_clk_i,
  input wire logic        arst_n_i,
  // watched ports
  input wire logic        wb_ack_o,
  input wire logic        supply_ok_i,
  input wire logic        external_reset_n_i,
  input wire vlc_nvm_t    nvm_cfg_i,
  input wire logic        err_valid_i,
  input wire logic        jtag_en_o,
  input wire logic        run_o,
  input wire logic [9:0]  vref_o,
  input wire logic        sample_o,
  input wire logic [11:0] duty_o,
  input wire logic        duty_valid_o
);
  default clocking dc @(posedge core_clk_i); endclocking
  default disable iff (!arst_n_i);
  logic [11:0] up_q;
  // edges seen with supply good and no external reset
  always_ff @(posedge core_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) up_q <= 12'h000;
    else if (!(supply_ok_i && external_reset_n_i)) up_q <= 12'h000;
    else if (up_q != 12'hfff) up_q <= up_q + 12'h001;
  end
  a_ack_pulse:
    assert property (wb_ack_o |=> !wb_ack_o) else $error("ack held");
  a_jtag_default:
    assert property ($rose(arst_n_i) |-> jtag_en_o) else $error("scan port off");
  a_supply_gate:
    assert property (!supply_ok_i |=> !run_o) else $error("run without supply");
  a_ext_reset:
    assert property (!external_reset_n_i |=> !run_o) else $error("run in reset");
  a_start_delay:
    assert property ($rose(run_o) |-> up_q >= 12'h7d1 && up_q <= 12'h7d2) else $error("startup");
  a_start_vref:
    assert property ($rose(run_o) |-> vref_o == nvm_cfg_i.vnom) else $error("vref not loaded");
  a_loop_latency:
    assert property (err_valid_i && run_o && supply_ok_i && external_reset_n_i |=> duty_valid_o)
      else $error("no duty");
  a_idle_quiet:
    assert property (!run_o |=> !duty_valid_o && !sample_o) else $error("activity outside run");
  a_duty_holds:
    assert property (run_o && $past(run_o) && !duty_valid_o |-> $stable(duty_o))
      else $error("duty moved");
  a_vref_step:
    assert property (run_o && $past(run_o) && $changed(vref_o) |->
      vref_o == $past(vref_o) + 10'h001 || vref_o == $past(vref_o) - 10'h001)
      else $error("vref jump");
  c_run: cover property ($rose(run_o));
  c_duty: cover property (duty_valid_o && duty_o != 12'h000);
  c_step: cover property (run_o && $past(run_o) && $changed(vref_o));
endmodule
bind vlc_top vlc_top_asserts u_chk (.core_clk_i, .arst_n_i, .wb_ack_o, .supply_ok_i,
  .external_reset_n_i, .nvm_cfg_i, .err_valid_i, .jtag_en_o, .run_o, .vref_o, .sample_o,
  .duty_o, .duty_valid_o);
`default_nettype wire

/* verif/vlc_sense_model.sv */
// error converter model: reference minus feedback, gained and clamped per sample
`timescale 1ns/1ps
`default_nettype none
module vlc_sense_model (
  // clock and reset
  input  wire logic       clk_i,
  input  wire logic       arst_n_i,
  // sample strobe, codes and gain
  input  wire logic       sample_i,
  input  wire logic [9:0] vref_i,
  input  wire logic [9:0] fb_i,
  input  wire logic [1:0] gcode_i,
  // converted error
  output logic            valid_o,
  output logic [5:0]      code_o
);
  int c;
  always @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      valid_o <= 1'b0;
      code_o <= 6'h00;
    end else begin
      c = (int'(vref_i) - int'(fb_i)) * 1563 / 1000 * (1 << gcode_i) / 8;
      c = c > 31 ? 31 : (c < -32 ? -32 : c);
      valid_o <= sample_i;
      // idle code toggles so a stale value is never trusted
      code_o <= sample_i ? 6'(c) : ~code_o;
    end
  end
endmodule
`default_nettype wire

/* verif/vlc_top_test.sv */
// self-checking bench of the voltage loop compensator
`timescale 1ns/1ps
`default_nettype none
module vlc_top_test import vlc_pkg::*; ;
  logic        clk, rst_n, cyc, stb, we, sup, xrst, ramp, light, tv, use_m;
  logic        ack, jtag, run, smp, dv, fm, m_v;
  logic [31:0] adr, wd, rd, rdat;
  logic [5:0]  te, m_c;
  logic [9:0]  fb, vref;
  logic [1:0]  gc;
  logic [11:0] duty;
  vlc_nvm_t    nvm;
  logic [5:0]  lim [3][4];
  logic [5:0]  rg [3][5];
  logic [9:0]  b0 [3];
  logic [1:0]  gk [3];
  int          err_count, n_tests, k, b, e, s;
  vlc_top uut (
    .core_clk_i(clk), .arst_n_i(rst_n), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we),
    .wb_adr_i(adr), .wb_sel_i(4'hf), .wb_dat_i(wd), .wb_ack_o(ack), .wb_dat_o(rdat),
    .supply_ok_i(sup), .external_reset_n_i(xrst), .nvm_cfg_i(nvm), .ramp_active_i(ramp),
    .light_load_i(light), .err_valid_i(use_m ? m_v : tv), .err_code_i(use_m ? m_c : te),
    .jtag_en_o(jtag), .run_o(run), .vref_o(vref), .front_end_gain_code_o(gc),
    .sample_o(smp), .duty_o(duty), .duty_valid_o(dv), .fault_mask_o(fm));
  vlc_sense_model u_sense (.clk_i(clk), .arst_n_i(rst_n), .sample_i(smp), .vref_i(vref),
    .fb_i(fb), .gcode_i(gc), .valid_o(m_v), .code_o(m_c));
  // core clock
  initial begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end
  task automatic chk(input string n, input logic [31:0] x, input logic [31:0] g);
    n_tests++;
    if (g !== x) begin
      $display("BAD %s exp %h got %h", n, x, g);
      err_count++;
    end
  endtask
  task automatic print_verdict();
    $display("checks %0d errors %0d", n_tests, err_count);
    if (err_count == 0 && n_tests > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask
  // one classic bus cycle, read data left in rd
  task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int i;
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= {24'h000000, a};
    wd <= d;
    i = 0;
    do begin
      @(posedge clk);
      i++;
    end while (ack !== 1'b1 && i < 20);
    rd = rdat;
    cyc <= 1'b0;
    stb <= 1'b0;
    if (ack !== 1'b1) begin
      err_count++;
      print_verdict();
    end
    @(posedge clk);
  endtask
  task automatic wait_run();
    k = 0;
    while (run !== 1'b1 && k < 3000) begin
      @(posedge clk);
      k++;
    end
    chk("startup", 32'h1, 32'(k >= 2002 && k <= 2003));
    chk("vref_load", 32'(nvm.vnom), 32'(vref));
    if (run !== 1'b1) print_verdict();
  endtask
  // loop model: region gain, b0 section, unity c0 section, clamp
  function automatic int mdl(int e, int b);
    int g;
    int y;
    g = rg[b][4];
    for (int i = 3; i >= 0; i--) if (e < $signed(lim[b][i])) g = rg[b][i];
    y = (((e * g) >>> 4) * $signed(b0[b])) >>> 8;
    return y < 0 ? 0 : (y > 4095 ? 4095 : y);
  endfunction
  // main sequence
  initial begin
    s = $urandom(47781);
    err_count = 0;
    n_tests = 0;
    {rst_n, cyc, stb, we, tv, use_m, ramp, light} = 8'h00;
    {sup, xrst} = 2'h3;
    {adr, wd} = 64'h0;
    te = 6'h00;
    fb = 10'h000;
    // stored targets stay far below the reference maximum
    nvm.vnom = 10'(300 + $urandom % 200);
    nvm.vhi = nvm.vnom;
    nvm.vlo = nvm.vnom;
    nvm.op = 3'h0;
    repeat (5) @(posedge clk);
    rst_n <= 1'b1;
    wait_run();
    chk("scan_en", 32'h1, 32'(jtag));
    wb(1'b0, 8'h00, 32'h0);
    chk("ctrl", 32'h1, rd);
    wb(1'b0, 8'h14, 32'h0);
    chk("time", 32'h012c0190, rd);
    wb(1'b1, 8'h24, 32'hffffffff);
    wb(1'b0, 8'h24, 32'h0);
    chk("unmapped", 32'h0, rd);
    wb(1'b1, 8'h00, 32'h0);
    chk("scan_off", 32'h0, 32'(jtag));
    for (k = 0; k < 8; k++) begin
      wb(1'b1, 8'h04, 32'(k));
      chk("fault_mask", 32'(k[2] && (k[1:0] == 1 || k[1:0] == 2)), 32'(fm));
    end
    for (b = 0; b < 3; b++) begin
      gk[b] = 2'($urandom);
      b0[b] = 10'($urandom % 512);
      for (k = 0; k < 4; k++) lim[b][k] = 6'($urandom);
      for (k = 0; k < 5; k++) rg[b][k] = 6'($urandom);
      wb(1'b1, 8'(64 + b * 32), {6'h0, lim[b][3], lim[b][2], lim[b][1], lim[b][0], gk[b]});
      wb(1'b1, 8'(68 + b * 32), {2'h0, rg[b][4], rg[b][3], rg[b][2], rg[b][1], rg[b][0]});
      wb(1'b1, 8'(72 + b * 32), {22'h0, b0[b]});
      wb(1'b1, 8'(80 + b * 32), 32'h100);
    end
    for (k = 0; k < 60; k++) begin
      b = k % 3;
      ramp <= (b == 0);
      light <= (b == 2);
      repeat (3) @(posedge clk);
      chk("gain_code", 32'(gk[b]), 32'(gc));
      e = $urandom_range(63) - 32;
      tv <= 1'b1;
      te <= 6'(e);
      @(posedge clk);
      tv <= 1'b0;
      @(posedge clk);
      chk("duty_valid", 32'h1, 32'(dv));
      chk("duty", 32'(mdl(e, b)), 32'(duty));
    end
    ramp <= 1'b0;
    light <= 1'b0;
    // a zero error clears saturation so the reference follows its target
    tv <= 1'b1;
    te <= 6'h00;
    @(posedge clk);
    tv <= 1'b0;
    for (k = 1; k < 3; k++) begin
      e = int'(vref);
      s = (k == 1) ? e + 2 : e - 2;
      wb(1'b1, 8'(8 + k * 4), 32'(s));
      wb(1'b1, 8'h04, 32'(k));
      repeat (6100) @(posedge clk);
      chk("margin_vref", 32'(s), 32'(vref));
    end
    k = 0;
    while (smp !== 1'b1 && k < 500) begin
      @(posedge clk);
      k++;
    end
    k = 0;
    do begin
      @(posedge clk);
      k++;
    end while (smp !== 1'b1 && k < 500);
    chk("sample_gap", 32'd401, 32'(k));
    use_m <= 1'b1;
    for (k = 0; k < 2; k++) begin
      e = 200 + $urandom % 100;
      fb <= k ? vref - 10'(e) : vref + 10'(e);
      repeat (500) @(posedge clk);
      e = int'(vref);
      repeat (4006) @(posedge clk);
      s = k ? e - int'(vref) : int'(vref) - e;
      chk("recovery", 32'h2, 32'(s));
    end
    for (b = 0; b < 2; b++) begin
      if (b == 0) xrst <= 1'b0;
      else sup <= 1'b0;
      repeat (2) @(posedge clk);
      chk("halted", 32'h0, 32'(run) | 32'(duty));
      xrst <= 1'b1;
      sup <= 1'b1;
      wait_run();
    end
    print_verdict();
  end
endmodule
`default_nettype wire
